/* verilog/scp_pkg.sv */
// Constants for the serial configuration port, shared by both link ends
package scp_pkg;
   localparam int WR_BITS = 73;
   localparam int RD_BITS = 30;
   localparam int WR_CNT_W = 7;
   localparam logic [WR_CNT_W-1:0] WR_LAST = 7'(WR_BITS - 1);
   localparam logic [WR_CNT_W-1:0] RD_LAST = 7'(RD_BITS - 1);
   // Write frame field positions, bit 0 is sent first
   localparam int CR_LSB = 0;
   localparam int CR_W = 3;
   localparam int DAC_DAT_LSB = 63;
   localparam int DAC_DAT_W = 8;
   localparam int DAC_SEL_BIT = 71;
   localparam int CLK_SEL_BIT = 72;
   // Read frame field positions
   localparam int LOCK_ALL_BIT = 0;
   localparam int LOCK_TC_BIT = 1;
   localparam int LOCK_PHASE_N_BIT = 2;
   localparam int ADC_DAT_LSB = 3;
   localparam int ADC_SEL_LSB = 15;
   // Settings held while the serial reset is asserted
   localparam logic [WR_BITS-1:0] WR_DEFAULT = {
      1'h0, 1'h0, 8'h80, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0,
      1'h0, 1'h0, 1'h0, 6'h03, 6'h02, 6'h00, 7'h00, 1'h0, 2'h0, 4'h1, 1'h0,
      12'h090, 4'h3, 3'h0};
   // Link clock made by the controller
   localparam int MCLK_NS = 40;
   localparam int LINK_PERIOD_NS = 320;
   localparam int HALF_CYC = LINK_PERIOD_NS / (2 * MCLK_NS);
   localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);
   // Controller register port
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] A_WORD0 = 8'h00;
   localparam logic [ADDR_W-1:0] A_WORD1 = 8'h04;
   localparam logic [ADDR_W-1:0] A_WORD2 = 8'h08;
   localparam logic [ADDR_W-1:0] A_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] A_CTRL = 8'h10;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_FULL_BIT = 1;
   localparam int CTRL_LINKUP_BIT = 2;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic {HS_IDLE, HS_RUN} scp_hstate_e;
endpackage : scp_pkg

/* verilog/scp_link_if.sv */
// Three-wire serial link plus serial reset between controller and device
`timescale 1ns/1ps
interface scp_link_if;
   logic serial_link_clock;
   logic serial_port_reset_n;
   logic config_serial_in;
   logic config_serial_out;
   modport dev (
      input serial_link_clock,
      input serial_port_reset_n,
      input config_serial_in,
      output config_serial_out
   );
   modport ctl (
      output serial_link_clock,
      output serial_port_reset_n,
      output config_serial_in,
      input config_serial_out
   );
endinterface : scp_link_if

/* verilog/scp_dev_end.sv */
// Device end: shifts in the setting frame and returns the status frame
`timescale 1ns/1ps
module scp_dev_end
   import scp_pkg::*;
(
   input wire logic MCLK,                         // System clock
   input wire logic RSTN,                         // Async reset, active low
   scp_link_if.dev link,                          // Serial link
   input wire logic [RD_BITS-1:0] STATUS_IN,      // Lock, ADC and version pins
   output logic [WR_BITS-1:0] CFG_WORD,           // All loaded settings
   output logic [CR_W-1:0] BUS_CLOCK_RATIO,       // Bus clock ratio field
   output logic [DAC_DAT_W-1:0] DAC_DATA,         // DAC data
   output logic DAC_SEL,                          // DAC select
   output logic CLK_SEL,                          // Clock select
   output logic MUX_EN,                           // Bus multiplexing enable
   output logic CORE_RESET_N                      // Test chip reset, active low
);
   localparam int SYNC_W = RD_BITS + 3;
   localparam int P_SCLK = RD_BITS;
   localparam int P_RSTN = RD_BITS + 1;
   localparam int P_SIN = RD_BITS + 2;

   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync1_next;
   logic [SYNC_W-1:0] sync2_reg;
   logic [SYNC_W-1:0] sync2_next;
   logic sclk_d_reg;
   logic sclk_d_next;
   logic [WR_CNT_W-1:0] cnt_reg;
   logic [WR_CNT_W-1:0] cnt_next;
   logic [WR_BITS-1:0] shift_reg;
   logic [WR_BITS-1:0] shift_next;
   logic [RD_BITS-1:0] stat_reg;
   logic [RD_BITS-1:0] stat_next;
   logic sout_reg;
   logic sout_next;
   logic [WR_BITS-1:0] cfg_reg;
   logic [WR_BITS-1:0] cfg_next;
   logic mux_en_reg;
   logic mux_en_next;
   logic core_rst_n_reg;
   logic core_rst_n_next;
   logic sclk_s;
   logic srst_n_s;
   logic sin_s;
   logic [RD_BITS-1:0] status_s;
   logic link_rise;

   // Pins from the link and the status inputs pass two flip-flops
   always_comb begin
      sync1_next = {link.config_serial_in, link.serial_port_reset_n,
                    link.serial_link_clock, STATUS_IN};
      sync2_next = sync1_reg;
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   assign sclk_s = sync2_reg[P_SCLK];
   assign srst_n_s = sync2_reg[P_RSTN];
   assign sin_s = sync2_reg[P_SIN];
   assign status_s = sync2_reg[RD_BITS-1:0];
   assign link_rise = sclk_s & ~sclk_d_reg;

   // Frame shifting, status return and output update
   always_comb begin
      sclk_d_next = sclk_s;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      stat_next = stat_reg;
      sout_next = sout_reg;
      cfg_next = cfg_reg;
      mux_en_next = mux_en_reg;
      core_rst_n_next = core_rst_n_reg;
      if (!srst_n_s) begin
         // Serial reset holds shift and setting logic at the initial state
         cnt_next = '0;
         shift_next = '0;
         cfg_next = WR_DEFAULT;
         mux_en_next = 1'b0;
         core_rst_n_next = 1'b0;
         stat_next = status_s;
         sout_next = status_s[0];
      end else if (link_rise) begin
         // Bit 0 arrives first and ends at the bottom of the frame
         shift_next = {sin_s, shift_reg[WR_BITS-1:1]};
         if (cnt_reg == WR_LAST) begin
            cnt_next = '0;
            cfg_next = {sin_s, shift_reg[WR_BITS-1:1]};
            mux_en_next = 1'b1;
            core_rst_n_next = 1'b1;
            stat_next = status_s;
            sout_next = status_s[0];
         end else begin
            cnt_next = cnt_reg + 7'h01;
            // Status shifts out bit 0 first; zeros follow bit 29
            stat_next = {1'b0, stat_reg[RD_BITS-1:1]};
            sout_next = stat_reg[1];
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_d_reg <= 1'b0;
         cnt_reg <= '0;
         shift_reg <= '0;
         stat_reg <= '0;
         sout_reg <= 1'b0;
         cfg_reg <= WR_DEFAULT;
         mux_en_reg <= 1'b0;
         core_rst_n_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_d_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         stat_reg <= stat_next;
         sout_reg <= sout_next;
         cfg_reg <= cfg_next;
         mux_en_reg <= mux_en_next;
         core_rst_n_reg <= core_rst_n_next;
      end
   end

   assign link.config_serial_out = sout_reg;
   assign CFG_WORD = cfg_reg;
   assign BUS_CLOCK_RATIO = cfg_reg[CR_LSB +: CR_W];
   assign DAC_DATA = cfg_reg[DAC_DAT_LSB +: DAC_DAT_W];
   assign DAC_SEL = cfg_reg[DAC_SEL_BIT];
   assign CLK_SEL = cfg_reg[CLK_SEL_BIT];
   assign MUX_EN = mux_en_reg;
   assign CORE_RESET_N = core_rst_n_reg;
endmodule : scp_dev_end

/* verilog/scp_ctl_end.sv */
// Controller end: setting FIFO, link clock divider and frame sender
`timescale 1ns/1ps
module scp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,                     // Clock
   input wire logic rst_n,                   // Async reset, active low
   input wire logic in_valid,                // Push request
   output logic in_ready,                    // Not full
   input wire logic [WIDTH-1:0] in_data,     // Push data
   output logic out_valid,                   // Not empty
   input wire logic out_ready,               // Pop request
   output logic [WIDTH-1:0] out_data         // Head word
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wp_reg;
   logic [PW-1:0] wp_next;
   logic [PW-1:0] rp_reg;
   logic [PW-1:0] rp_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   // Not-full is kept as a flop so the ready output needs no gate after it
   logic nfull_reg;
   logic nfull_next;
   logic empty_reg;
   logic empty_next;
   logic push;
   logic pop;

   assign push = in_valid & nfull_reg;
   assign pop = out_ready & ~empty_reg;

   always_comb begin
      wp_next = push ? PW'(wp_reg + 1'b1) : wp_reg;
      rp_next = pop ? PW'(rp_reg + 1'b1) : rp_reg;
      cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
      nfull_next = (cnt_next != CW'(DEPTH));
      empty_next = (cnt_next == '0);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
         nfull_reg <= 1'b1;
         empty_reg <= 1'b1;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
         nfull_reg <= nfull_next;
         empty_reg <= empty_next;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end

   assign in_ready = nfull_reg;
   assign out_valid = ~empty_reg;
   assign out_data = mem_reg[rp_reg];
endmodule : scp_fifo

module scp_ctl_end
   import scp_pkg::*;
(
   input wire logic MCLK,                    // System clock
   input wire logic RSTN,                    // Async reset, active low
   scp_link_if.ctl link,                     // Serial link
   input wire logic [ADDR_W-1:0] ADDR,       // Register address
   input wire logic [31:0] WDATA,            // Write data
   input wire logic WR,                      // Write strobe
   input wire logic RD,                      // Read strobe
   output logic [31:0] RDATA,                // Read data, cycle after RD
   output logic CFG_READY                    // Setting FIFO can take a frame
);
   scp_hstate_e state_reg;
   scp_hstate_e state_next;
   logic [2:0] div_reg;
   logic [2:0] div_next;
   logic sclk_reg;
   logic sclk_next;
   logic srst_n_reg;
   logic srst_n_next;
   logic sdo_reg;
   logic sdo_next;
   logic [WR_CNT_W-1:0] bit_reg;
   logic [WR_CNT_W-1:0] bit_next;
   logic [WR_BITS-1:0] tx_reg;
   logic [WR_BITS-1:0] tx_next;
   logic [WR_BITS-1:0] txsh_reg;
   logic [WR_BITS-1:0] txsh_next;
   logic [RD_BITS-1:0] rxsh_reg;
   logic [RD_BITS-1:0] rxsh_next;
   logic [RD_BITS-1:0] rx_reg;
   logic [RD_BITS-1:0] rx_next;
   logic [63:0] stage_reg;
   logic [63:0] stage_next;
   logic run_reg;
   logic run_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic sout_s1_reg;
   logic sout_s2_reg;
   logic wrap;
   logic fall_ev;
   logic rise_ev;
   logic push;
   logic pop;
   logic fifo_valid;
   logic fifo_ready;
   logic [WR_BITS-1:0] fifo_data;

   assign push = WR & (ADDR == A_WORD2);

   scp_fifo #(.WIDTH(WR_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(MCLK),
      .rst_n(RSTN),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data({WDATA[WR_BITS-65:0], stage_reg}),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data)
   );

   assign wrap = (div_reg == HALF_LAST);
   assign fall_ev = wrap & sclk_reg;
   assign rise_ev = wrap & ~sclk_reg;
   // New settings are taken only between frames
   assign pop = (state_reg == HS_IDLE) |
                (rise_ev & (bit_reg == WR_LAST));

   always_comb begin
      state_next = state_reg;
      div_next = wrap ? '0 : 3'(div_reg + 3'h1);
      sclk_next = wrap ? ~sclk_reg : sclk_reg;
      srst_n_next = srst_n_reg;
      sdo_next = sdo_reg;
      bit_next = bit_reg;
      tx_next = (pop & fifo_valid) ? fifo_data : tx_reg;
      txsh_next = txsh_reg;
      rxsh_next = rxsh_reg;
      rx_next = rx_reg;
      unique case (state_reg)
         HS_IDLE: begin
            srst_n_next = 1'b0;
            bit_next = '0;
            txsh_next = tx_next;
            // Reset is released on a falling edge along with bit 0
            if (run_reg && fall_ev) begin
               state_next = HS_RUN;
               srst_n_next = 1'b1;
               sdo_next = tx_next[0];
               txsh_next = {1'b0, tx_next[WR_BITS-1:1]};
            end
         end
         HS_RUN: begin
            if (!run_reg) begin
               state_next = HS_IDLE;
               srst_n_next = 1'b0;
            end else if (fall_ev) begin
               sdo_next = txsh_reg[0];
               txsh_next = {1'b0, txsh_reg[WR_BITS-1:1]};
            end else if (rise_ev) begin
               if (bit_reg <= RD_LAST) begin
                  rxsh_next = {sout_s2_reg, rxsh_reg[RD_BITS-1:1]};
               end
               if (bit_reg == RD_LAST) begin
                  rx_next = {sout_s2_reg, rxsh_reg[RD_BITS-1:1]};
               end
               if (bit_reg == WR_LAST) begin
                  bit_next = '0;
                  txsh_next = tx_next;
               end else begin
                  bit_next = bit_reg + 7'h01;
               end
            end
         end
      endcase
   end

   // Register port
   always_comb begin
      stage_next = stage_reg;
      run_next = run_reg;
      rdata_next = '0;
      if (WR && ADDR == A_WORD0) begin
         stage_next[31:0] = WDATA;
      end
      if (WR && ADDR == A_WORD1) begin
         stage_next[63:32] = WDATA;
      end
      if (WR && ADDR == A_CTRL) begin
         run_next = WDATA[CTRL_RUN_BIT];
      end
      if (RD) begin
         unique case (ADDR)
            A_WORD0: rdata_next = tx_reg[31:0];
            A_WORD1: rdata_next = tx_reg[63:32];
            A_WORD2: rdata_next = {23'h000000, tx_reg[WR_BITS-1:64]};
            A_STATUS: rdata_next = {2'h0, rx_reg};
            A_CTRL: begin
               rdata_next[CTRL_RUN_BIT] = run_reg;
               rdata_next[CTRL_FULL_BIT] = ~fifo_ready;
               rdata_next[CTRL_LINKUP_BIT] = (state_reg == HS_RUN);
            end
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg <= HS_IDLE;
         div_reg <= '0;
         sclk_reg <= 1'b0;
         srst_n_reg <= 1'b0;
         sdo_reg <= 1'b0;
         bit_reg <= '0;
         tx_reg <= WR_DEFAULT;
         txsh_reg <= WR_DEFAULT;
         rxsh_reg <= '0;
         rx_reg <= '0;
         stage_reg <= '0;
         run_reg <= 1'b0;
         rdata_reg <= '0;
         sout_s1_reg <= 1'b0;
         sout_s2_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         div_reg <= div_next;
         sclk_reg <= sclk_next;
         srst_n_reg <= srst_n_next;
         sdo_reg <= sdo_next;
         bit_reg <= bit_next;
         tx_reg <= tx_next;
         txsh_reg <= txsh_next;
         rxsh_reg <= rxsh_next;
         rx_reg <= rx_next;
         stage_reg <= stage_next;
         run_reg <= run_next;
         rdata_reg <= rdata_next;
         sout_s1_reg <= link.config_serial_out;
         sout_s2_reg <= sout_s1_reg;
      end
   end

   assign link.serial_link_clock = sclk_reg;
   assign link.serial_port_reset_n = srst_n_reg;
   assign link.config_serial_in = sdo_reg;
   assign RDATA = rdata_reg;
   assign CFG_READY = fifo_ready;
endmodule : scp_ctl_end

/* verif/scp_link_sva.sv */
// Concurrent checks on the three-wire serial link between the two ends
`timescale 1ns/1ps
module scp_link_sva
   import scp_pkg::*;
(
   input wire logic MCLK,                  // System clock
   input wire logic RSTN,                  // Async reset, active low
   input wire logic serial_link_clock,     // Link clock
   input wire logic serial_port_reset_n,   // Serial reset, active low
   input wire logic config_serial_in,      // Data toward device
   input wire logic config_serial_out      // Data back to controller
);
   logic sclk_reg;
   logic [6:0] slot_reg;
   logic [6:0] slot_next;
   logic rise;

   // Index of the current link rise within the 73-slot frame
   assign rise = serial_link_clock & ~sclk_reg;
   always_comb begin
      slot_next = slot_reg;
      if (!serial_port_reset_n) begin
         slot_next = 7'h00;
      end else if (rise) begin
         slot_next = (slot_reg == WR_LAST) ? 7'h00 : slot_reg + 7'h01;
      end
   end
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_reg <= 1'b0;
         slot_reg <= 7'h00;
      end else begin
         sclk_reg <= serial_link_clock;
         slot_reg <= slot_next;
      end
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);

   sequence high_half;
      serial_link_clock [*4];
   endsequence
   sequence low_half;
      !serial_link_clock [*4];
   endsequence

   a_link_period_run: assert property (disable iff (!RSTN || !serial_port_reset_n)
      $rose(serial_link_clock) |-> high_half ##1 low_half ##1 serial_link_clock)
      else $error("link clock period or run broken");
   a_data_on_fall: assert property (
      $changed(config_serial_in) |-> !serial_port_reset_n || $fell(serial_link_clock))
      else $error("serial data changed off a falling link edge");
   a_capture_stable: assert property (disable iff (!RSTN || !serial_port_reset_n)
      $rose(serial_link_clock) |-> $stable(config_serial_in) throughout high_half)
      else $error("serial data moved while link clock high");
   a_reset_release_fall: assert property (
      $rose(serial_port_reset_n) |-> $fell(serial_link_clock))
      else $error("serial reset released off a falling edge");
   a_first_rise_gap: assert property (disable iff (!RSTN || !serial_port_reset_n)
      $rose(serial_port_reset_n) |-> low_half ##1 serial_link_clock)
      else $error("first link rise not one half period after release");
   a_bit_holds_period: assert property (disable iff (!RSTN || !serial_port_reset_n)
      $changed(config_serial_in) |=> $stable(config_serial_in) [*7])
      else $error("serial data bit shorter than a link period");
   a_pad_slots_zero: assert property (disable iff (!RSTN || !serial_port_reset_n)
      rise && (slot_reg >= 7'h1e) |-> !config_serial_out)
      else $error("read slot beyond the status bits not zero");
   a_out_quiet_rise: assert property (disable iff (!RSTN || !serial_port_reset_n)
      $rose(serial_link_clock) |-> $stable(config_serial_out))
      else $error("return data changed at a link rise");
endmodule : scp_link_sva

/* verif/serial_config_port_tb.sv */
// Self-checking bench joining controller and device across the serial link
`timescale 1ns/1ps
module serial_config_port_tb;
   import scp_pkg::*;
   logic mclk;
   logic rstn;
   logic [ADDR_W-1:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic [31:0] got;
   logic cfg_ready;
   logic [RD_BITS-1:0] status_in;
   logic [WR_BITS-1:0] cfg_word;
   logic [WR_BITS-1:0] prev_word;
   logic [CR_W-1:0] ratio;
   logic [DAC_DAT_W-1:0] dac_data;
   logic dac_sel;
   logic clk_sel;
   logic mux_en;
   logic core_reset_n;
   logic [WR_BITS-1:0] fr [0:5];
   logic [WR_BITS-1:0] legal [$];
   integer miscompares;
   integer checked;
   integer cycles;
   integer seed;
   integer i;

   scp_link_if link();
   scp_ctl_end i_scp_ctl_end(.MCLK(mclk), .RSTN(rstn), .link(link.ctl), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CFG_READY(cfg_ready));
   scp_dev_end i_scp_dev_end(.MCLK(mclk), .RSTN(rstn), .link(link.dev),
      .STATUS_IN(status_in), .CFG_WORD(cfg_word), .BUS_CLOCK_RATIO(ratio),
      .DAC_DATA(dac_data), .DAC_SEL(dac_sel), .CLK_SEL(clk_sel), .MUX_EN(mux_en),
      .CORE_RESET_N(core_reset_n));
   scp_link_sva i_scp_link_sva(.MCLK(mclk), .RSTN(rstn),
      .serial_link_clock(link.serial_link_clock),
      .serial_port_reset_n(link.serial_port_reset_n),
      .config_serial_in(link.config_serial_in), .config_serial_out(link.config_serial_out));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic print_verdict();
      if (miscompares == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   task automatic chk_frame(input logic [WR_BITS-1:0] g, input logic [WR_BITS-1:0] e);
      checked = checked + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %0t frame got %h exp %h", $time, g, e);
      end
   endtask : chk_frame

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      checked = checked + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %0t word got %h exp %h", $time, g, e);
      end
   endtask : chk_reg

   task automatic chk_bit(input logic g, input logic e);
      checked = checked + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %0t flag got %b exp %b", $time, g, e);
      end
   endtask : chk_bit

   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      // One idle edge keeps the next call from touching the strobe in this step
      wr <= 1'b0;
      @(posedge mclk);
   endtask : bus_wr

   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      // Read data stand only in the cycle after the strobe; take them at its closing edge
      @(posedge mclk);
      d = rdata;
   endtask : bus_rd

   task automatic push(input logic [WR_BITS-1:0] f);
      bus_wr(A_WORD0, f[31:0]);
      bus_wr(A_WORD1, f[63:32]);
      bus_wr(A_WORD2, {23'h0, f[72:64]});
   endtask : push

   task automatic wait_frame(input logic [WR_BITS-1:0] f);
      int n;
      for (n = 0; n < 2000 && cfg_word !== f; n++) @(posedge mclk);
      chk_frame(cfg_word, f);
   endtask : wait_frame

   task automatic chk_outs(input logic [WR_BITS-1:0] f);
      chk_reg({29'h0, ratio}, {29'h0, f[CR_LSB +: CR_W]});
      chk_reg({24'h0, dac_data}, {24'h0, f[DAC_DAT_LSB +: DAC_DAT_W]});
      chk_bit(dac_sel, f[DAC_SEL_BIT]);
      chk_bit(clk_sel, f[CLK_SEL_BIT]);
      chk_bit(mux_en, 1'b1);
      chk_bit(core_reset_n, 1'b1);
   endtask : chk_outs

   task automatic wait_status();
      int n;
      for (n = 0; n < 2000; n++) begin
         bus_rd(A_STATUS, got);
         if (got === {2'h0, status_in}) break;
      end
      chk_reg(got, {2'h0, status_in});
   endtask : wait_status

   function automatic logic is_legal(input logic [WR_BITS-1:0] w);
      foreach (legal[k]) if (legal[k] === w) return 1'b1;
      return 1'b0;
   endfunction : is_legal

   // Settings may only ever show WR_DEFAULT or whole frames that were really sent
   always @(posedge mclk) begin
      if (rstn === 1'b1 && cfg_word !== prev_word) chk_bit(is_legal(cfg_word), 1'b1);
      prev_word <= cfg_word;
   end

   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %0t timeout", $time);
         print_verdict();
      end
   end

   initial begin
      seed = 32'h74d58962;
      miscompares = 0;
      checked = 0;
      cycles = 0;
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      prev_word = WR_DEFAULT;
      status_in = RD_BITS'($random(seed));
      fr[0] = 73'h1;
      fr[1] = {WR_BITS{1'b1}};
      for (i = 2; i < 6; i++) fr[i] = WR_BITS'({$random(seed), $random(seed), $random(seed)});
      legal.push_back(WR_DEFAULT);
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      chk_frame(cfg_word, WR_DEFAULT);
      chk_bit(mux_en, 1'b0);
      chk_bit(core_reset_n, 1'b0);
      chk_bit(link.serial_port_reset_n, 1'b0);
      chk_bit(cfg_ready, 1'b1);
      bus_rd(A_CTRL, got);
      chk_reg(got, 32'h0);
      bus_rd(8'h20, got);
      chk_reg(got, 32'h0);
      repeat (100) @(posedge mclk);
      chk_frame(cfg_word, WR_DEFAULT);
      legal.push_back(fr[0]);
      push(fr[0]);
      bus_wr(A_CTRL, 32'h1);
      wait_frame(fr[0]);
      chk_outs(fr[0]);
      // Stay clear of the next frame end before filling the FIFO
      repeat (40) @(posedge mclk);
      for (i = 1; i < 5; i++) begin
         legal.push_back(fr[i]);
         push(fr[i]);
      end
      bus_rd(A_CTRL, got);
      bus_rd(A_CTRL, got);
      chk_reg(got, 32'h7);
      chk_bit(cfg_ready, 1'b0);
      push(fr[5]);
      for (i = 1; i < 5; i++) wait_frame(fr[i]);
      chk_outs(fr[4]);
      chk_bit(cfg_ready, 1'b1);
      bus_rd(A_WORD0, got);
      chk_reg(got, fr[4][31:0]);
      bus_rd(A_WORD1, got);
      chk_reg(got, fr[4][63:32]);
      bus_rd(A_WORD2, got);
      chk_reg(got, {23'h0, fr[4][72:64]});
      repeat (1200) @(posedge mclk);
      chk_frame(cfg_word, fr[4]);
      for (i = 0; i < 2; i++) begin
         status_in <= RD_BITS'($random(seed));
         wait_status();
      end
      bus_wr(A_CTRL, 32'h0);
      wait_frame(WR_DEFAULT);
      chk_bit(mux_en, 1'b0);
      chk_bit(core_reset_n, 1'b0);
      legal.push_back(fr[5]);
      push(fr[5]);
      bus_wr(A_CTRL, 32'h1);
      wait_frame(fr[5]);
      chk_outs(fr[5]);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      chk_frame(cfg_word, WR_DEFAULT);
      chk_bit(link.serial_port_reset_n, 1'b0);
      chk_bit(cfg_ready, 1'b1);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      print_verdict();
   end
endmodule : serial_config_port_tb
